// ---- rtl/iptm_regs.svh ----
// Register offsets, field positions, reset values and timing constants of the I/O threshold monitor
`ifndef IPTM_REGS_SVH
`define IPTM_REGS_SVH
`define IPTM_ADDR_W          8
`define IPTM_DATA_W          16
`define IPTM_OFF_IN_POL_LO   8'h00
`define IPTM_OFF_IN_POL_HI   8'h01
`define IPTM_OFF_REGEN_SEL   8'h02
`define IPTM_OFF_OVL_LIMIT   8'h03
`define IPTM_OFF_HOT_LIMIT   8'h04
`define IPTM_OFF_OUT_POL     8'h05
`define IPTM_OFF_TRQ_LEVEL   8'h06
`define IPTM_OFF_TRQ_TIME    8'h07
`define IPTM_OFF_STATUS      8'h08
`define IPTM_OFF_IRQ_STAT    8'h09
`define IPTM_OFF_IRQ_MASK    8'h0A
`define IPTM_OFF_TRQ_TIME_ACT 8'h0B
`define IPTM_RST_POL         16'h0000
`define IPTM_RST_REGEN       16'h0000
`define IPTM_RST_OVL_LIMIT   16'h0073
`define IPTM_RST_HOT_LIMIT   16'h0064
`define IPTM_RST_TRQ_LEVEL   16'h0064
`define IPTM_RST_TRQ_TIME    16'h0000
`define IPTM_RST_MASK        3'h0
`define IPTM_IRQ_OVL_BIT     0
`define IPTM_IRQ_HOT_BIT     1
`define IPTM_IRQ_TRQ_BIT     2
`define IPTM_IRQ_W           3
`define IPTM_CLK_HZ          10000000
`define IPTM_MS_PER_S        1000
`define IPTM_CYC_PER_MS      (`IPTM_CLK_HZ / `IPTM_MS_PER_S)
`define IPTM_MS_CNT_W        14
`define IPTM_DIGIT_W         4
`define IPTM_DIGITS          4
`endif

// ---- rtl/iptm_pkg.sv ----
// Types of the I/O threshold monitor
`default_nettype none
package iptm_pkg;
  typedef enum logic [2:0] {
    IPTM_TRQ_OFF     = 3'b001,
    IPTM_TRQ_QUALIFY = 3'b010,
    IPTM_TRQ_ON      = 3'b100
  } iptm_trq_state_t;
endpackage : iptm_pkg
`default_nettype wire

// ---- rtl/iptm_polarity.sv ----
// Per-terminal polarity inversion stage
`default_nettype none
module iptm_polarity #(
  parameter int N = 8
) (
  // Clock and reset
  input  wire logic         ref_clk_in,
  input  wire logic         rst_in,
  // Levels
  input  wire logic [N-1:0] level_in,
  input  wire logic [N-1:0] invert_in,
  output logic      [N-1:0] level_out
);
  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_bit
      logic level_ff;
      always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
          level_ff <= 1'b0;
        end else begin
          level_ff <= invert_in[i] ? ~level_in[i] : level_in[i];
        end
      end
      assign level_out[i] = level_ff;
      AST_POL_MAP: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        !$past(rst_in) |-> level_ff == ($past(level_in[i]) ^ $past(invert_in[i])))
        else $error("Polarity stage output does not follow level and invert bit");
    end
  endgenerate
endmodule : iptm_polarity
`default_nettype wire

// ---- rtl/iptm_monitor.sv ----
// I/O polarity conditioning and threshold supervision with register port
// Summary of operation
// - Each of eight input terminals passes unchanged with polarity bit 0 and inverted with bit 1.
// - Input terminals 0-3 take polarity from digits 0-3 of the low setting, terminals 4-7 from the high setting.
// - Each of four output terminal pairs has its own polarity bit, 0 unchanged and 1 inverted.
// - The overload alarm rises when the load percentage is above the overload limit.
// - The overheat alarm rises when the winding temperature is above the overheat limit.
// - The torque-detected output is on above the torque level and off below it, in percent.
// - The torque detection time in ms is held and only takes effect after a restart.
// - Regen select 0 means an external resistor is fitted, 1 means none and internal capacitance is used.
//
// The strobed register port and the register offsets were decided locally.
`default_nettype none
`include "iptm_regs.svh"
module iptm_monitor
  import iptm_pkg::*;
(
  // Clock and reset
  input  wire logic                    ref_clk_in,
  input  wire logic                    rst_in,
  // Register port
  input  wire logic [`IPTM_ADDR_W-1:0] reg_addr_in,
  input  wire logic [`IPTM_DATA_W-1:0] reg_wdata_in,
  input  wire logic                    reg_wr_in,
  input  wire logic                    reg_rd_in,
  output logic      [`IPTM_DATA_W-1:0] reg_rdata_out,
  // Input terminals
  input  wire logic [7:0]              term_in,
  output logic      [7:0]              term_cond_out,
  // Output terminals
  input  wire logic [3:0]              out_sig_in,
  output logic      [3:0]              out_term_out,
  // Measurements
  input  wire logic [`IPTM_DATA_W-1:0] load_pct_in,
  input  wire logic [`IPTM_DATA_W-1:0] winding_temp_in,
  input  wire logic [`IPTM_DATA_W-1:0] torque_pct_in,
  // Alarms and status
  output logic                         overload_alarm_out,
  output logic                         motor_overheat_alarm_out,
  output logic                         torque_detected_out,
  output logic                         regen_external_out,
  output logic                         irq_out
);
  logic [`IPTM_DATA_W-1:0] in_pol_lo_ff;
  logic [`IPTM_DATA_W-1:0] in_pol_hi_ff;
  logic [`IPTM_DATA_W-1:0] regen_sel_ff;
  logic [`IPTM_DATA_W-1:0] ovl_limit_ff;
  logic [`IPTM_DATA_W-1:0] hot_limit_ff;
  logic [`IPTM_DATA_W-1:0] out_pol_ff;
  logic [`IPTM_DATA_W-1:0] trq_level_ff;
  logic [`IPTM_DATA_W-1:0] trq_time_ff = `IPTM_RST_TRQ_TIME;
  logic [`IPTM_DATA_W-1:0] trq_time_act_ff;
  logic                    restart_seen_ff;
  logic [`IPTM_IRQ_W-1:0]  irq_stat_ff;
  logic [`IPTM_IRQ_W-1:0]  irq_mask_ff;
  logic [`IPTM_DATA_W-1:0] rdata_ff;
  logic                    ovl_ff;
  logic                    hot_ff;
  logic                    trq_raw_ff;
  logic                    trq_out_ff;
  logic [`IPTM_MS_CNT_W-1:0] ms_div_ff;
  logic [`IPTM_DATA_W-1:0] ms_cnt_ff;
  iptm_trq_state_t         trq_state_ff;
  iptm_trq_state_t         nxt_trq_state;
  logic [7:0]              in_invert;
  logic [3:0]              out_invert;
  logic                    wr_hit;
  logic                    ovl_rise;
  logic                    hot_rise;
  logic                    trq_rise;
  logic                    ms_tick;
  logic [`IPTM_DATA_W-1:0] nxt_rdata;

  // A polarity digit is a hex digit set to 0 or 1, so only its low bit counts
  genvar d;
  generate
    for (d = 0; d < `IPTM_DIGITS; d++) begin : g_digit
      assign in_invert[d]              = in_pol_lo_ff[d*`IPTM_DIGIT_W];
      assign in_invert[d+`IPTM_DIGITS] = in_pol_hi_ff[d*`IPTM_DIGIT_W];
      assign out_invert[d]             = out_pol_ff[d*`IPTM_DIGIT_W];
    end
  endgenerate

  iptm_polarity #(.N(8)) u_in_pol (
    .ref_clk_in (ref_clk_in),
    .rst_in     (rst_in),
    .level_in   (term_in),
    .invert_in  (in_invert),
    .level_out  (term_cond_out)
  );

  iptm_polarity #(.N(4)) u_out_pol (
    .ref_clk_in (ref_clk_in),
    .rst_in     (rst_in),
    .level_in   (out_sig_in),
    .invert_in  (out_invert),
    .level_out  (out_term_out)
  );

  // Configuration registers, all effective at once except the torque time
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      in_pol_lo_ff <= `IPTM_RST_POL;
      in_pol_hi_ff <= `IPTM_RST_POL;
      regen_sel_ff <= `IPTM_RST_REGEN;
      ovl_limit_ff <= `IPTM_RST_OVL_LIMIT;
      hot_limit_ff <= `IPTM_RST_HOT_LIMIT;
      out_pol_ff   <= `IPTM_RST_POL;
      trq_level_ff <= `IPTM_RST_TRQ_LEVEL;
      // Torque time is a stored setting: a restart keeps it, so only power-up sets it
      irq_mask_ff  <= `IPTM_RST_MASK;
    end else if (reg_wr_in) begin
      case (reg_addr_in)
        `IPTM_OFF_IN_POL_LO: in_pol_lo_ff <= reg_wdata_in;
        `IPTM_OFF_IN_POL_HI: in_pol_hi_ff <= reg_wdata_in;
        `IPTM_OFF_REGEN_SEL: regen_sel_ff <= reg_wdata_in;
        // Values of 120 or more are accepted; keeping below that is up to software
        `IPTM_OFF_OVL_LIMIT: ovl_limit_ff <= reg_wdata_in;
        `IPTM_OFF_HOT_LIMIT: hot_limit_ff <= reg_wdata_in;
        `IPTM_OFF_OUT_POL:   out_pol_ff   <= reg_wdata_in;
        `IPTM_OFF_TRQ_LEVEL: trq_level_ff <= reg_wdata_in;
        `IPTM_OFF_TRQ_TIME:  trq_time_ff  <= reg_wdata_in;
        `IPTM_OFF_IRQ_MASK:  irq_mask_ff  <= reg_wdata_in[`IPTM_IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  // Torque time is latched once after reset release, so later writes wait for a restart
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      restart_seen_ff <= 1'b0;
      trq_time_act_ff <= `IPTM_RST_TRQ_TIME;
    end else if (!restart_seen_ff) begin
      restart_seen_ff <= 1'b1;
      trq_time_act_ff <= trq_time_ff;
    end
  end

  // Regen select: only bit 0 is meaningful
  assign regen_external_out = ~regen_sel_ff[0];

  // Alarms register the comparison of the live measurements, so they show one cycle after they arrive
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      ovl_ff <= 1'b0;
      hot_ff <= 1'b0;
    end else begin
      ovl_ff <= load_pct_in > ovl_limit_ff;
      hot_ff <= winding_temp_in > hot_limit_ff;
    end
  end
  assign overload_alarm_out       = ovl_ff;
  assign motor_overheat_alarm_out = hot_ff;

  // Raw comparison with hold on equality
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      trq_raw_ff <= 1'b0;
    end else if (torque_pct_in > trq_level_ff) begin
      trq_raw_ff <= 1'b1;
    end else if (torque_pct_in < trq_level_ff) begin
      trq_raw_ff <= 1'b0;
    end
  end // Equal keeps the previous value

  // Millisecond time base
  // Runs only while qualifying, so a dip of torque below the level restarts the whole detection time
  assign ms_tick = (ms_div_ff == `IPTM_MS_CNT_W'(`IPTM_CYC_PER_MS - 1));
  always_ff @(posedge ref_clk_in) begin
    if (rst_in || trq_state_ff != IPTM_TRQ_QUALIFY) begin
      ms_div_ff <= '0;
    end else begin
      ms_div_ff <= ms_tick ? '0 : ms_div_ff + 1'b1;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in || trq_state_ff != IPTM_TRQ_QUALIFY) begin
      ms_cnt_ff <= '0;
    end else if (ms_tick) begin
      ms_cnt_ff <= ms_cnt_ff + 1'b1;
    end
  end

  // Output turns on once torque has stayed high for the active time; zero means at once
  always_comb begin
    nxt_trq_state = trq_state_ff;
    case (trq_state_ff)
      IPTM_TRQ_OFF: begin
        if (trq_raw_ff) begin
          nxt_trq_state = (trq_time_act_ff == '0) ? IPTM_TRQ_ON : IPTM_TRQ_QUALIFY;
        end
      end
      IPTM_TRQ_QUALIFY: begin
        if (!trq_raw_ff) begin
          nxt_trq_state = IPTM_TRQ_OFF;
        end else if (ms_tick && ms_cnt_ff + 1'b1 >= trq_time_act_ff) begin
          nxt_trq_state = IPTM_TRQ_ON;
        end
      end
      IPTM_TRQ_ON: begin
        if (!trq_raw_ff) begin
          nxt_trq_state = IPTM_TRQ_OFF;
        end
      end
      default: nxt_trq_state = IPTM_TRQ_OFF;
    endcase
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      trq_state_ff <= IPTM_TRQ_OFF;
      trq_out_ff   <= 1'b0;
    end else begin
      trq_state_ff <= nxt_trq_state;
      trq_out_ff   <= (nxt_trq_state == IPTM_TRQ_ON);
    end
  end
  assign torque_detected_out = trq_out_ff;

  // Sticky events; a new event in the clearing cycle wins over the clear
  assign ovl_rise = (load_pct_in > ovl_limit_ff) && !ovl_ff;
  assign hot_rise = (winding_temp_in > hot_limit_ff) && !hot_ff;
  assign trq_rise = (nxt_trq_state == IPTM_TRQ_ON) && !trq_out_ff;
  assign wr_hit   = reg_wr_in && (reg_addr_in == `IPTM_OFF_IRQ_STAT);

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      irq_stat_ff <= '0;
    end else begin
      irq_stat_ff <= (irq_stat_ff & ~(wr_hit ? reg_wdata_in[`IPTM_IRQ_W-1:0] : '0))
                   | {trq_rise, hot_rise, ovl_rise};
    end
  end
  assign irq_out = |(irq_stat_ff & irq_mask_ff);

  // Read port; unmapped offsets read as zero
  always_comb begin
    nxt_rdata = '0;
    case (reg_addr_in)
      `IPTM_OFF_IN_POL_LO:    nxt_rdata = in_pol_lo_ff;
      `IPTM_OFF_IN_POL_HI:    nxt_rdata = in_pol_hi_ff;
      `IPTM_OFF_REGEN_SEL:    nxt_rdata = regen_sel_ff;
      `IPTM_OFF_OVL_LIMIT:    nxt_rdata = ovl_limit_ff;
      `IPTM_OFF_HOT_LIMIT:    nxt_rdata = hot_limit_ff;
      `IPTM_OFF_OUT_POL:      nxt_rdata = out_pol_ff;
      `IPTM_OFF_TRQ_LEVEL:    nxt_rdata = trq_level_ff;
      `IPTM_OFF_TRQ_TIME:     nxt_rdata = trq_time_ff;
      `IPTM_OFF_STATUS:       nxt_rdata = {12'h000, regen_external_out, trq_out_ff, hot_ff, ovl_ff};
      `IPTM_OFF_IRQ_STAT:     nxt_rdata = {13'h0000, irq_stat_ff};
      `IPTM_OFF_IRQ_MASK:     nxt_rdata = {13'h0000, irq_mask_ff};
      `IPTM_OFF_TRQ_TIME_ACT: nxt_rdata = trq_time_act_ff;
      default:                nxt_rdata = '0;
    endcase
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      rdata_ff <= '0;
    end else begin
      rdata_ff <= reg_rd_in ? nxt_rdata : '0;
    end
  end
  assign reg_rdata_out = rdata_ff;

  AST_OVL_ALARM: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    $past(load_pct_in) > $past(ovl_limit_ff) && !$past(rst_in) |-> overload_alarm_out)
    else $error("Overload alarm missing after load above limit");
  AST_HOT_ALARM: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    !$past(rst_in) |-> motor_overheat_alarm_out == ($past(winding_temp_in) > $past(hot_limit_ff)))
    else $error("Overheat alarm disagrees with temperature and limit");
  AST_TRQ_EQ_HOLD: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    torque_pct_in == trq_level_ff |=> $stable(trq_raw_ff))
    else $error("Torque comparison changed on equality");
  AST_TRQ_OFF: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    torque_pct_in < trq_level_ff |-> ##2 !torque_detected_out)
    else $error("Torque output not off two cycles after torque below level");
  AST_TRQ_ON_ZERO: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    trq_time_act_ff == '0 && torque_pct_in > trq_level_ff ##1 trq_raw_ff |-> ##1 torque_detected_out)
    else $error("Torque output not on with zero detection time");
  AST_TRQ_TIME_HELD: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    restart_seen_ff && $past(restart_seen_ff) |-> $stable(trq_time_act_ff))
    else $error("Active torque time changed without restart");
  AST_REGEN: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    regen_sel_ff[0] == 1'b0 |-> regen_external_out)
    else $error("Regen select zero does not mean external resistor");
  AST_IN_POL_MAP: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    !$past(rst_in) |-> term_cond_out[7:4] == ($past(term_in[7:4]) ^
      $past({in_pol_hi_ff[3*`IPTM_DIGIT_W], in_pol_hi_ff[2*`IPTM_DIGIT_W], in_pol_hi_ff[`IPTM_DIGIT_W], in_pol_hi_ff[0]})))
    else $error("High input terminals not inverted by high setting");
  AST_IN_POL_LO: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    !$past(rst_in) |-> term_cond_out[3:0] == ($past(term_in[3:0]) ^
      $past({in_pol_lo_ff[3*`IPTM_DIGIT_W], in_pol_lo_ff[2*`IPTM_DIGIT_W], in_pol_lo_ff[`IPTM_DIGIT_W], in_pol_lo_ff[0]})))
    else $error("Low input terminals not inverted by low setting");
  AST_OUT_POL_MAP: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    !$past(rst_in) |-> out_term_out == ($past(out_sig_in) ^
      $past({out_pol_ff[3*`IPTM_DIGIT_W], out_pol_ff[2*`IPTM_DIGIT_W], out_pol_ff[`IPTM_DIGIT_W], out_pol_ff[0]})))
    else $error("Output terminals not inverted by output polarity");
  AST_READ_LAT: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    !reg_rd_in |=> reg_rdata_out == '0)
    else $error("Read data present without read strobe");
  AST_OVL_CLEAR: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    !$past(rst_in) && $past(load_pct_in) <= $past(ovl_limit_ff) |-> !overload_alarm_out)
    else $error("Overload alarm present with load not above limit");
  AST_TRQ_EARLY: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    trq_time_act_ff != '0 && $rose(trq_raw_ff) |-> ##2 !torque_detected_out)
    else $error("Torque output on before the detection time ran");
  AST_QUAL_TIME: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    trq_time_act_ff == '0 |-> trq_state_ff != IPTM_TRQ_QUALIFY)
    else $error("Torque qualification running with zero detection time");
  AST_MS_RANGE: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (ms_div_ff <= `IPTM_MS_CNT_W'(`IPTM_CYC_PER_MS - 1)))
    else $error("Millisecond divider beyond its terminal count");
  AST_REGEN_NONE: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    regen_sel_ff[0] |-> !regen_external_out)
    else $error("Regen select one still reports an external resistor");

  // Interrupt, restart and register checks
  AST_OVL_IRQ: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    $rose(overload_alarm_out) |-> irq_stat_ff[`IPTM_IRQ_OVL_BIT])
    else $error("Overload rise did not set its status bit");
  AST_HOT_IRQ: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    $rose(motor_overheat_alarm_out) |-> irq_stat_ff[`IPTM_IRQ_HOT_BIT])
    else $error("Overheat rise did not set its status bit");
  AST_TRQ_IRQ: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    $rose(torque_detected_out) |-> irq_stat_ff[`IPTM_IRQ_TRQ_BIT])
    else $error("Torque output rise did not set its status bit");
  AST_IRQ_CLEAR: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    wr_hit && reg_wdata_in[`IPTM_IRQ_OVL_BIT] && !ovl_rise |=> !irq_stat_ff[`IPTM_IRQ_OVL_BIT])
    else $error("Writing one did not clear the overload status bit");
  AST_IRQ_LEVEL: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    irq_stat_ff[`IPTM_IRQ_OVL_BIT] && irq_mask_ff[`IPTM_IRQ_OVL_BIT] |-> irq_out)
    else $error("Unmasked overload status without interrupt");
  AST_RESTART_LATCH: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    !restart_seen_ff |=> trq_time_act_ff == $past(trq_time_ff))
    else $error("Active torque time not taken from the setting at restart");
  AST_READ_DATA: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    reg_rd_in && reg_addr_in == `IPTM_OFF_TRQ_TIME_ACT |=> reg_rdata_out == $past(trq_time_act_ff))
    else $error("Read data of active torque time wrong");

  COV_OVL: cover property (@(posedge ref_clk_in) disable iff (rst_in) $rose(overload_alarm_out));
  COV_HOT: cover property (@(posedge ref_clk_in) disable iff (rst_in) $rose(motor_overheat_alarm_out));
  COV_TRQ_QUAL: cover property (@(posedge ref_clk_in) disable iff (rst_in)
    trq_state_ff == IPTM_TRQ_QUALIFY ##1 trq_state_ff == IPTM_TRQ_ON);
  COV_IRQ: cover property (@(posedge ref_clk_in) disable iff (rst_in) $rose(irq_out));
  COV_RESTART: cover property (@(posedge ref_clk_in) disable iff (rst_in) $rose(restart_seen_ff));
endmodule : iptm_monitor
`default_nettype wire

// ---- tb/iptm_term_model.sv ----
// Behavioural model of the controller wired to the discrete I/O terminals
`default_nettype none
module iptm_term_model (
  // Clock
  input  wire logic       ref_clk_in,
  // Stimulus and observation
  input  wire logic [7:0] pattern_in,
  input  wire logic [3:0] out_term_in,
  output logic      [7:0] term_out,
  output logic      [3:0] seen_out
);
  timeunit 1ns;
  timeprecision 1ns;
  initial term_out = 8'h00;
  initial seen_out = 4'h0;
  // Terminals change just after an edge, like a real controller's output latch
  always @(posedge ref_clk_in) begin
    term_out <= pattern_in;
    seen_out <= out_term_in;
  end
endmodule : iptm_term_model
`default_nettype wire

// ---- tb/tb.sv ----
// Self-checking bench of the I/O threshold monitor
`default_nettype none
`include "iptm_regs.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        ref_clk_in      = 1'b0;
  logic        rst_in          = 1'b1;
  logic [7:0]  reg_addr_in     = 8'h00;
  logic [15:0] reg_wdata_in    = 16'h0000;
  logic        reg_wr_in       = 1'b0;
  logic        reg_rd_in       = 1'b0;
  logic [15:0] reg_rdata_out;
  logic [7:0]  pattern         = 8'h00;
  logic [7:0]  term_in;
  logic [7:0]  term_cond_out;
  logic [3:0]  out_sig_in      = 4'h0;
  logic [3:0]  out_term_out;
  logic [3:0]  seen;
  logic [15:0] load_pct_in     = 16'h0000;
  logic [15:0] winding_temp_in = 16'h0000;
  logic [15:0] torque_pct_in   = 16'h0000;
  logic        overload_alarm_out;
  logic        motor_overheat_alarm_out;
  logic        torque_detected_out;
  logic        regen_external_out;
  logic        irq_out;
  int          fail_count      = 0;
  int          n_checks        = 0;

  always #50 ref_clk_in = ~ref_clk_in;

  iptm_monitor dut_u (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
    .term_in(term_in), .term_cond_out(term_cond_out), .out_sig_in(out_sig_in), .out_term_out(out_term_out),
    .load_pct_in(load_pct_in), .winding_temp_in(winding_temp_in), .torque_pct_in(torque_pct_in),
    .overload_alarm_out(overload_alarm_out), .motor_overheat_alarm_out(motor_overheat_alarm_out),
    .torque_detected_out(torque_detected_out), .regen_external_out(regen_external_out), .irq_out(irq_out));

  iptm_term_model ctl_u (.ref_clk_in(ref_clk_in), .pattern_in(pattern), .out_term_in(out_term_out),
    .term_out(term_in), .seen_out(seen));

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic step(input int n);
    repeat (n) @(posedge ref_clk_in);
    #1;
  endtask : step

  // One idle edge before each strobe keeps a strobe from being set and cleared in one step
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge ref_clk_in);
    reg_addr_in  <= a;
    reg_wdata_in <= d;
    reg_wr_in    <= 1'b1;
    @(posedge ref_clk_in);
    reg_wr_in    <= 1'b0;
  endtask : wr

  task automatic rd_check(input logic [7:0] a, input logic [15:0] exp);
    @(posedge ref_clk_in);
    reg_addr_in <= a;
    reg_rd_in   <= 1'b1;
    @(posedge ref_clk_in);
    reg_rd_in   <= 1'b0;
    #1;
    check(reg_rdata_out, exp);
  endtask : rd_check

  task automatic t_reset;
    rd_check(`IPTM_OFF_OVL_LIMIT, `IPTM_RST_OVL_LIMIT);
    rd_check(`IPTM_OFF_TRQ_LEVEL, `IPTM_RST_TRQ_LEVEL);
    rd_check(`IPTM_OFF_REGEN_SEL, `IPTM_RST_REGEN);
    check(16'(regen_external_out), 16'h0001);
    rd_check(8'h20, 16'h0000);
  endtask : t_reset

  // Digits of value 0 and 1 only, so reading just the low bit of each digit gives the intended setting
  task automatic t_in_pol;
    wr(`IPTM_OFF_IN_POL_LO, 16'h0101);
    wr(`IPTM_OFF_IN_POL_HI, 16'h1010);
    @(posedge ref_clk_in);
    pattern <= 8'hFF;
    step(2);
    check(16'(term_cond_out), 16'h005A);
    @(posedge ref_clk_in);
    pattern <= 8'h0F;
    step(2);
    check(16'(term_cond_out), 16'h00AA);
  endtask : t_in_pol

  task automatic t_out_pol;
    wr(`IPTM_OFF_OUT_POL, 16'h1001);
    @(posedge ref_clk_in);
    out_sig_in <= 4'h3;
    step(1);
    check(16'(out_term_out), 16'h000A);
    step(1);
    check(16'(seen), 16'h000A);
  endtask : t_out_pol

  task automatic t_overload;
    wr(`IPTM_OFF_OVL_LIMIT, 16'h0064);
    wr(`IPTM_OFF_IRQ_MASK, 16'h0001);
    @(posedge ref_clk_in);
    load_pct_in <= 16'h0064;
    step(1);
    check(16'(overload_alarm_out), 16'h0000);
    @(posedge ref_clk_in);
    load_pct_in <= 16'h0065;
    step(1);
    check(16'(overload_alarm_out), 16'h0001);
    step(1);
    check(16'(irq_out), 16'h0001);
    rd_check(`IPTM_OFF_IRQ_STAT, 16'h0001);
    @(posedge ref_clk_in);
    load_pct_in <= 16'h0000;
    step(1);
    check(16'(overload_alarm_out), 16'h0000);
    wr(`IPTM_OFF_IRQ_STAT, 16'h0001);
    step(1);
    check(16'(irq_out), 16'h0000);
  endtask : t_overload

  task automatic t_overheat;
    wr(`IPTM_OFF_HOT_LIMIT, 16'h0050);
    @(posedge ref_clk_in);
    winding_temp_in <= 16'h0050;
    step(1);
    check(16'(motor_overheat_alarm_out), 16'h0000);
    @(posedge ref_clk_in);
    winding_temp_in <= 16'h0051;
    step(1);
    check(16'(motor_overheat_alarm_out), 16'h0001);
    @(posedge ref_clk_in);
    winding_temp_in <= 16'h0000;
    step(1);
    check(16'(motor_overheat_alarm_out), 16'h0000);
  endtask : t_overheat

  // Torque time is 0 after reset, so the output follows the comparator directly
  task automatic t_torque;
    wr(`IPTM_OFF_TRQ_LEVEL, 16'h0032);
    @(posedge ref_clk_in);
    torque_pct_in <= 16'h0033;
    step(2);
    check(16'(torque_detected_out), 16'h0001);
    @(posedge ref_clk_in);
    torque_pct_in <= 16'h0032;
    step(3);
    check(16'(torque_detected_out), 16'h0001);
    @(posedge ref_clk_in);
    torque_pct_in <= 16'h0031;
    step(2);
    check(16'(torque_detected_out), 16'h0000);
    @(posedge ref_clk_in);
    torque_pct_in <= 16'h0032;
    step(3);
    check(16'(torque_detected_out), 16'h0000);
    rd_check(`IPTM_OFF_IRQ_STAT, 16'h0006);
  endtask : t_torque

  task automatic t_regen_time;
    wr(`IPTM_OFF_TRQ_TIME, 16'h0001);
    rd_check(`IPTM_OFF_TRQ_TIME, 16'h0001);
    rd_check(`IPTM_OFF_TRQ_TIME_ACT, 16'h0000);
    wr(`IPTM_OFF_REGEN_SEL, 16'h0001);
    step(1);
    check(16'(regen_external_out), 16'h0000);
    wr(`IPTM_OFF_REGEN_SEL, 16'h0000);
    step(1);
    check(16'(regen_external_out), 16'h0001);
  endtask : t_regen_time

  // A restart applies the stored 1 ms torque time: qualification then takes one ms of cycles
  task automatic t_restart;
    @(posedge ref_clk_in);
    rst_in        <= 1'b1;
    torque_pct_in <= 16'h0000;
    step(2);
    check(16'(torque_detected_out), 16'h0000);
    @(posedge ref_clk_in);
    rst_in <= 1'b0;
    rd_check(`IPTM_OFF_TRQ_TIME, 16'h0001);
    rd_check(`IPTM_OFF_TRQ_TIME_ACT, 16'h0001);
    rd_check(`IPTM_OFF_TRQ_LEVEL, `IPTM_RST_TRQ_LEVEL);
    @(posedge ref_clk_in);
    torque_pct_in <= 16'h0065;
    step(`IPTM_CYC_PER_MS + 1);
    check(16'(torque_detected_out), 16'h0000);
    step(1);
    check(16'(torque_detected_out), 16'h0001);
  endtask : t_restart

  task automatic tally_and_finish;
    if (fail_count == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    repeat (2) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    t_reset();
    t_in_pol();
    t_out_pol();
    t_overload();
    t_overheat();
    t_torque();
    t_regen_time();
    t_restart();
    tally_and_finish();
  end

  // The sequence needs about 10,100 cycles, most of them the 1 ms qualification
  initial begin
    repeat (20000) @(posedge ref_clk_in);
    fail_count++;
    tally_and_finish();
  end
endmodule : tb
`default_nettype wire
